// >>> verilog/debug_access_pkg.sv
package debug_access_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Target select codes and reset values

    localparam logic [7:0] SEL_PART_ID = 8'h00;
    localparam logic [7:0] SEL_SILICON_REV = 8'h01;
    localparam logic [7:0] SEL_FLASH_CTL = 8'h02;
    localparam logic [7:0] SEL_FLASH_DATA = 8'hB4;
    localparam logic [7:0] TARGET_SELECT_RESET = 8'h00;
    localparam logic [7:0] FLASH_CTL_RESET = 8'h00;
    localparam logic [7:0] FLASH_DATA_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Programming unlock sequence and flash command codes

    localparam logic [7:0] UNLOCK_FIRST = 8'h02;
    localparam logic [7:0] UNLOCK_SECOND = 8'h01;
    localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
    localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
    localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;

    ////////////////////////////////////////////////////////////////////////////////
    // Link framing: instruction codes, bit counts

    localparam logic [1:0] INS_DATA_READ = 2'b00;
    localparam logic [1:0] INS_DATA_WRITE = 2'b01;
    localparam logic [1:0] INS_ADDR_READ = 2'b10;
    localparam logic [1:0] INS_ADDR_WRITE = 2'b11;
    localparam logic [3:0] INS_LAST_BIT = 4'h1;
    localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        LINK_IDLE = 3'b000,
        LINK_INS = 3'b001,
        LINK_WDAT = 3'b011,
        LINK_WAIT = 3'b010,
        LINK_RDAT = 3'b110
    } link_state_type;

    typedef enum logic [1:0] {
        PROG_LOCKED = 2'b00,
        PROG_HALF = 2'b01,
        PROG_OPEN = 2'b11
    } prog_unlock_type;

endpackage

// >>> verilog/debug_reg_core.sv
module debug_reg_core #(
    // Arbitrary value, not tied to any real part
    parameter logic [7:0] PART_ID = 8'h5A
) (
    // System clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Request from the link domain, words stable while a request is pending
    input wire logic req_tgl,
    input wire logic req_wr,
    input wire logic [7:0] req_addr,
    input wire logic [7:0] req_wdata,
    // Answer to the link domain
    output logic ack_tgl,
    output logic [7:0] ack_rdata,
    // Die revision straps
    input wire logic [7:0] silicon_revision_pin,
    // Flash programming engine
    input wire logic flash_cmd_phase,
    input wire logic [7:0] flash_rd_data,
    output logic flash_prog_enabled,
    output logic [7:0] flash_prog_data,
    output logic flash_data_wr,
    output logic flash_data_rd,
    output logic [7:0] flash_cmd,
    output logic flash_cmd_bad,
    output logic [7:0] flash_prog_control
);

    typedef struct packed {
        logic req_m;
        logic req_s;
        logic req_seen;
        logic ack;
        logic [7:0] rdata;
        logic [7:0] rev_m;
        logic [7:0] rev_s;
        logic [7:0] fpc;
        debug_access_pkg::prog_unlock_type unlock;
        logic [7:0] fpd;
        logic wr_p;
        logic rd_p;
        logic [7:0] cmd;
        logic cmd_bad;
    } core_state_type;

    core_state_type state_q;
    core_state_type state_d;
    logic cmd_ok;

    ////////////////////////////////////////////////////////////////////////////////
    // Register access, one per request toggle

    always_comb begin
        state_d = state_q;
        state_d.wr_p = 1'b0;
        state_d.rd_p = 1'b0;
        state_d.req_m = req_tgl;
        state_d.req_s = state_q.req_m;
        state_d.rev_m = silicon_revision_pin;
        state_d.rev_s = state_q.rev_m;
        cmd_ok = (req_wdata == debug_access_pkg::CMD_BLOCK_READ)
            || (req_wdata == debug_access_pkg::CMD_BLOCK_WRITE)
            || (req_wdata == debug_access_pkg::CMD_PAGE_ERASE)
            || (req_wdata == debug_access_pkg::CMD_DEVICE_ERASE);
        if (state_q.req_s != state_q.req_seen) begin
            state_d.req_seen = state_q.req_s;
            state_d.ack = ~state_q.ack;
            state_d.rdata = debug_access_pkg::READ_UNMAPPED;
            case (req_addr)
                debug_access_pkg::SEL_PART_ID: begin
                    // Writes fall through untouched
                    if (!req_wr) begin
                        state_d.rdata = PART_ID;
                    end
                end
                debug_access_pkg::SEL_SILICON_REV: begin
                    if (!req_wr) begin
                        state_d.rdata = state_q.rev_s;
                    end
                end
                debug_access_pkg::SEL_FLASH_CTL: begin
                    if (req_wr) begin
                        state_d.fpc = req_wdata;
                        // Once open, only a system reset closes it again
                        if (state_q.unlock != debug_access_pkg::PROG_OPEN) begin
                            if (state_q.unlock == debug_access_pkg::PROG_HALF
                                    && req_wdata == debug_access_pkg::UNLOCK_SECOND) begin
                                state_d.unlock = debug_access_pkg::PROG_OPEN;
                            end else if (req_wdata == debug_access_pkg::UNLOCK_FIRST) begin
                                state_d.unlock = debug_access_pkg::PROG_HALF;
                            end else begin
                                state_d.unlock = debug_access_pkg::PROG_LOCKED;
                            end
                        end
                    end else begin
                        state_d.rdata = state_q.fpc;
                    end
                end
                debug_access_pkg::SEL_FLASH_DATA: begin
                    // Flash traffic is refused until the unlock sequence is done
                    if (state_q.unlock == debug_access_pkg::PROG_OPEN) begin
                        if (req_wr) begin
                            state_d.fpd = req_wdata;
                            state_d.wr_p = 1'b1;
                            if (flash_cmd_phase) begin
                                state_d.cmd_bad = ~cmd_ok;
                                if (cmd_ok) begin
                                    state_d.cmd = req_wdata;
                                end
                            end
                        end else begin
                            state_d.rdata = flash_rd_data;
                            state_d.rd_p = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '{
                req_m: 1'b0, req_s: 1'b0, req_seen: 1'b0, ack: 1'b0,
                rdata: debug_access_pkg::READ_UNMAPPED,
                rev_m: 8'h00, rev_s: 8'h00,
                fpc: debug_access_pkg::FLASH_CTL_RESET,
                unlock: debug_access_pkg::PROG_LOCKED,
                fpd: debug_access_pkg::FLASH_DATA_RESET,
                wr_p: 1'b0, rd_p: 1'b0, cmd: 8'h00, cmd_bad: 1'b0
            };
        end else begin
            state_q <= state_d;
        end
    end

    assign ack_tgl = state_q.ack;
    assign ack_rdata = state_q.rdata;
    assign flash_prog_enabled = (state_q.unlock == debug_access_pkg::PROG_OPEN);
    assign flash_prog_data = state_q.fpd;
    assign flash_data_wr = state_q.wr_p;
    assign flash_data_rd = state_q.rd_p;
    assign flash_cmd = state_q.cmd;
    assign flash_cmd_bad = state_q.cmd_bad;
    assign flash_prog_control = state_q.fpc;

endmodule

// >>> verilog/debug_link.sv
module debug_link #(
    // Arbitrary value, not tied to any real part
    parameter logic [7:0] PART_ID = 8'h5A
) (
    // System clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Two-wire debug link
    input wire logic debug_clock_pin,
    input wire logic debug_data_in,
    output logic debug_data_out,
    output logic debug_data_oe_b,
    // Die revision straps
    input wire logic [7:0] silicon_revision_pin,
    // Flash programming engine
    input wire logic flash_cmd_phase,
    input wire logic [7:0] flash_rd_data,
    output logic flash_prog_enabled,
    output logic [7:0] flash_prog_data,
    output logic flash_data_wr,
    output logic flash_data_rd,
    output logic [7:0] flash_cmd,
    output logic flash_cmd_bad,
    output logic [7:0] flash_prog_control,
    // Link-side view of the target select
    output logic [7:0] debug_target_select
);

    // Link-side state, all on the host's clock
    typedef struct packed {
        debug_access_pkg::link_state_type state;
        logic [3:0] cnt;
        logic [1:0] ins;
        logic [7:0] shift;
        logic [7:0] sel;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic req;
        logic ack_m;
        logic ack_s;
        logic dout;
        logic drive;
    } link_type;

    link_type link_q;
    link_type link_d;
    // Answer from the system side; its data word is registered on the same system clock edge as the toggle
    logic ack_tgl;
    logic [7:0] ack_rdata;
    logic [1:0] ins_full;
    logic [7:0] byte_full;

    ////////////////////////////////////////////////////////////////////////////////
    // Register side on the system clock

    debug_reg_core #(
        .PART_ID(PART_ID)
    ) u_core (
        .clk(clk),
        .rst_b(rst_b),
        .req_tgl(link_q.req),
        .req_wr(link_q.wr),
        .req_addr(link_q.addr),
        .req_wdata(link_q.wdata),
        .ack_tgl(ack_tgl),
        .ack_rdata(ack_rdata),
        .silicon_revision_pin(silicon_revision_pin),
        .flash_cmd_phase(flash_cmd_phase),
        .flash_rd_data(flash_rd_data),
        .flash_prog_enabled(flash_prog_enabled),
        .flash_prog_data(flash_prog_data),
        .flash_data_wr(flash_data_wr),
        .flash_data_rd(flash_data_rd),
        .flash_cmd(flash_cmd),
        .flash_cmd_bad(flash_cmd_bad),
        .flash_prog_control(flash_prog_control)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Link framing on the host's clock
    // The host clock stops between frames, so every frame ends on its own edges:
    // the last driven bit is released on the edge after it.

    always_comb begin
        link_d = link_q;
        link_d.ack_m = ack_tgl;
        link_d.ack_s = link_q.ack_m;
        // Instruction bits arrive LSB first, so each new bit enters at the top
        ins_full = {debug_data_in, link_q.ins[1]};
        byte_full = {debug_data_in, link_q.shift[7:1]};
        case (link_q.state)
            debug_access_pkg::LINK_IDLE: begin
                // A low bit on an undriven line opens a frame
                if (link_q.drive) begin
                    // The hand-back edge itself never opens a frame
                    link_d.drive = 1'b0;
                end else if (!debug_data_in) begin
                    link_d.state = debug_access_pkg::LINK_INS;
                    link_d.cnt = 4'h0;
                end
            end
            debug_access_pkg::LINK_INS: begin
                link_d.ins = ins_full;
                link_d.cnt = link_q.cnt + 4'h1;
                if (link_q.cnt == debug_access_pkg::INS_LAST_BIT) begin
                    link_d.cnt = 4'h0;
                    case (ins_full)
                        debug_access_pkg::INS_DATA_READ: begin
                            // Target chosen by the select held at issue time
                            link_d.addr = link_q.sel;
                            link_d.wr = 1'b0;
                            link_d.req = ~link_q.req;
                            link_d.drive = 1'b1;
                            link_d.dout = 1'b0;
                            link_d.state = debug_access_pkg::LINK_WAIT;
                        end
                        debug_access_pkg::INS_ADDR_READ: begin
                            // Ready goes out at once, no system-side round trip
                            link_d.shift = link_q.sel;
                            link_d.drive = 1'b1;
                            link_d.dout = 1'b1;
                            link_d.state = debug_access_pkg::LINK_RDAT;
                        end
                        debug_access_pkg::INS_DATA_WRITE: begin
                            // The request leaves only once the whole byte is in
                            link_d.state = debug_access_pkg::LINK_WDAT;
                        end
                        debug_access_pkg::INS_ADDR_WRITE: begin
                            // Device stays off the line for this whole frame
                            link_d.state = debug_access_pkg::LINK_WDAT;
                        end
                        default: begin
                            link_d.state = debug_access_pkg::LINK_IDLE;
                        end
                    endcase
                end
            end
            debug_access_pkg::LINK_WDAT: begin
                link_d.shift = byte_full;
                link_d.cnt = link_q.cnt + 4'h1;
                if (link_q.cnt == debug_access_pkg::BYTE_LAST_BIT) begin
                    link_d.cnt = 4'h0;
                    if (link_q.ins == debug_access_pkg::INS_ADDR_WRITE) begin
                        // A new select only steers requests issued after it
                        link_d.sel = byte_full;
                        link_d.state = debug_access_pkg::LINK_IDLE;
                    end else begin
                        link_d.addr = link_q.sel;
                        link_d.wdata = byte_full;
                        link_d.wr = 1'b1;
                        link_d.req = ~link_q.req;
                        link_d.drive = 1'b1;
                        link_d.dout = 1'b0;
                        link_d.state = debug_access_pkg::LINK_WAIT;
                    end
                end
            end
            debug_access_pkg::LINK_WAIT: begin
                // Wait bits stay low until the system side has answered
                // No bound here: a host that stops clocking stalls the frame
                if (link_q.ack_s == link_q.req) begin
                    link_d.dout = 1'b1;
                    if (link_q.wr) begin
                        link_d.state = debug_access_pkg::LINK_IDLE;
                    end else begin
                        // Answer word has been stable since the toggle left
                        link_d.shift = ack_rdata;
                        link_d.cnt = 4'h0;
                        link_d.state = debug_access_pkg::LINK_RDAT;
                    end
                end
            end
            debug_access_pkg::LINK_RDAT: begin
                link_d.cnt = link_q.cnt + 4'h1;
                link_d.dout = link_q.shift[link_q.cnt[2:0]];
                // Ninth edge after ready hands the line back
                if (link_q.cnt == debug_access_pkg::BYTE_BITS) begin
                    link_d.cnt = 4'h0;
                    link_d.dout = 1'b0;
                    link_d.drive = 1'b0;
                    link_d.state = debug_access_pkg::LINK_IDLE;
                end
            end
            // Unused state codes fall back to idle with the line released
            default: begin
                link_d.state = debug_access_pkg::LINK_IDLE;
                link_d.drive = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link registers
    // Reset release is not synced to the link clock: the host keeps it still then
    always_ff @(posedge debug_clock_pin or negedge rst_b) begin
        if (!rst_b) begin
            link_q <= '{
                state: debug_access_pkg::LINK_IDLE,
                cnt: 4'h0,
                ins: 2'b00,
                shift: 8'h00,
                sel: debug_access_pkg::TARGET_SELECT_RESET,
                addr: 8'h00,
                wdata: 8'h00,
                wr: 1'b0,
                req: 1'b0,
                ack_m: 1'b0,
                ack_s: 1'b0,
                dout: 1'b0,
                drive: 1'b0
            };
        end else begin
            link_q <= link_d;
        end
    end

    // Only path to these registers is this pin pair
    assign debug_data_out = link_q.dout;
    // Low enable means the device owns the wire
    assign debug_data_oe_b = ~link_q.drive;
    assign debug_target_select = link_q.sel;

endmodule

// >>> sim/debug_link_assertions.sv
module debug_link_assertions (
    // System side
    input wire logic clk,
    input wire logic rst_b,
    // Link side
    input wire logic debug_clock_pin,
    input wire logic debug_data_oe_b,
    input wire logic [7:0] debug_target_select,
    // Flash engine
    input wire logic flash_prog_enabled,
    input wire logic flash_data_wr,
    input wire logic flash_data_rd,
    input wire logic [7:0] flash_cmd,
    input wire logic [7:0] flash_prog_control
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_drive_begin;
        $fell(debug_data_oe_b);
    endsequence
    // A stuck driver would block the host forever, so the hand-back is bounded
    sequence s_release;
        ##[1:30] debug_data_oe_b;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    a_select_reset_value: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> debug_target_select == 8'h00 && !flash_prog_enabled)
        else $error("target select or unlock not clear after reset");
    a_enable_sticky: assert property (@(posedge clk) disable iff (!rst_b)
        flash_prog_enabled |=> flash_prog_enabled)
        else $error("programming enable dropped without reset");
    a_unlock_last: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(flash_prog_enabled) |-> flash_prog_control == 8'h01)
        else $error("programming enabled without final unlock write");
    a_write_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        flash_data_wr |=> !flash_data_wr)
        else $error("flash data write pulse longer than one cycle");
    a_read_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        flash_data_rd |=> !flash_data_rd)
        else $error("flash data read pulse longer than one cycle");
    a_access_gated: assert property (@(posedge clk) disable iff (!rst_b)
        flash_data_wr || flash_data_rd |-> flash_prog_enabled)
        else $error("flash data access while locked");
    a_cmd_legal: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(flash_cmd) |-> flash_prog_enabled
            && flash_cmd inside {8'h06, 8'h07, 8'h08, 8'h03})
        else $error("flash command took an invalid code");
    a_select_quiet: assert property (@(posedge debug_clock_pin) disable iff (!rst_b)
        $changed(debug_target_select) |-> debug_data_oe_b)
        else $error("target select changed while device drives");
    a_release_bound: assert property (@(posedge debug_clock_pin) disable iff (!rst_b)
        s_drive_begin |-> s_release)
        else $error("data line not released in time");
endmodule

// >>> sim/debug_host_model.sv
module debug_host_model (
    // Two-wire link
    output logic debug_clock_pin,
    output logic debug_data_in,
    input wire logic debug_data_out,
    input wire logic debug_data_oe_b
);
    timeunit 1ns;
    timeprecision 100ps;
    logic host_en = 1'b0;
    logic host_bit = 1'b0;
    logic last_q = 1'b0;

    // No pull on the line: a released wire must not echo the last bit
    assign debug_data_in = !debug_data_oe_b ? debug_data_out : host_en ? host_bit : !last_q;
    always @(posedge debug_clock_pin) last_q <= debug_data_in;
    initial debug_clock_pin = 1'b0;

    // Clock only runs inside frames; data moves while the clock is low
    task automatic pulse(input logic rel, output logic smp);
        #7.5 debug_clock_pin = 1'b1;
        smp = debug_data_in;
        // Letting go on the rising edge would race the device's sample
        #7.5 debug_clock_pin = 1'b0;
        if (rel) host_en = 1'b0;
    endtask

    task automatic frame(input logic [1:0] ins, input logic [7:0] wb,
            output logic [7:0] rb, output logic ok);
        logic s;
        int n;
        rb = 8'h00;
        ok = 1'b1;
        host_en = 1'b1;
        host_bit = 1'b0;
        pulse(1'b0, s);
        for (int i = 0; i < 2; i++) begin
            host_bit = ins[i];
            pulse(i == 1 && !ins[0], s);
        end
        if (ins[0]) begin
            for (int i = 0; i < 8; i++) begin
                host_bit = wb[i];
                pulse(i == 7, s);
            end
        end
        if (ins != 2'b11) begin
            n = 0;
            s = 1'b0;
            while (s !== 1'b1 && n < 20) begin
                pulse(1'b0, s);
                n++;
            end
            ok = s;
            if (!ins[0]) begin
                for (int i = 0; i < 8; i++) begin
                    pulse(1'b0, s);
                    rb[i] = s;
                end
            end
            // No edge past the release: a floating wire could open a false frame
        end
    endtask
endmodule

// >>> sim/debug_link_tb.sv
module debug_link_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] PART_CODE = 8'hC3; // Arbitrary value
    localparam logic [7:0] REV_CODE = 8'hA6;
    logic clk, rst_b, debug_clock_pin, debug_data_in, debug_data_out, debug_data_oe_b;
    logic flash_cmd_phase, flash_prog_enabled, flash_data_wr, flash_data_rd, flash_cmd_bad;
    logic [7:0] silicon_revision_pin, flash_rd_data, flash_prog_data, flash_cmd;
    logic [7:0] flash_prog_control, debug_target_select, v;
    logic [7:0] cmds [4] = '{8'h06, 8'h07, 8'h08, 8'h03};
    int error_cnt = 0;
    int cmp_count = 0;
    int wr_pulses = 0;
    int rd_pulses = 0;

    debug_link #(.PART_ID(PART_CODE)) dut_u (.clk(clk), .rst_b(rst_b),
        .debug_clock_pin(debug_clock_pin), .debug_data_in(debug_data_in),
        .debug_data_out(debug_data_out), .debug_data_oe_b(debug_data_oe_b),
        .silicon_revision_pin(silicon_revision_pin), .flash_cmd_phase(flash_cmd_phase),
        .flash_rd_data(flash_rd_data), .flash_prog_enabled(flash_prog_enabled),
        .flash_prog_data(flash_prog_data), .flash_data_wr(flash_data_wr),
        .flash_data_rd(flash_data_rd), .flash_cmd(flash_cmd), .flash_cmd_bad(flash_cmd_bad),
        .flash_prog_control(flash_prog_control), .debug_target_select(debug_target_select));
    debug_host_model host_u (.debug_clock_pin(debug_clock_pin), .debug_data_in(debug_data_in),
        .debug_data_out(debug_data_out), .debug_data_oe_b(debug_data_oe_b));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (flash_data_wr === 1'b1) wr_pulses++;
        if (flash_data_rd === 1'b1) rd_pulses++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic [1:0] ins, input logic [7:0] wb, output logic [7:0] rb);
        logic ok;
        host_u.frame(ins, wb, rb, ok);
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH ready expected 1 seen %b", ok);
            stop_test();
        end
    endtask
    // Waits let the system-side pulse land before ports are compared
    task automatic data_wr(input logic [7:0] d);
        xfer(2'b01, d, v);
        repeat (4) @(negedge clk);
    endtask
    task automatic data_rd();
        xfer(2'b00, 8'h00, v);
        repeat (4) @(negedge clk);
    endtask
    task automatic do_reset();
        @(negedge clk) rst_b = 1'b0;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        silicon_revision_pin = REV_CODE;
        flash_cmd_phase = 1'b0;
        flash_rd_data = 8'h3E;
        do_reset();
        data_rd();
        check8("part id after reset", PART_CODE, v);
        xfer(2'b10, 8'h00, v);
        check8("select after reset", 8'h00, v);
        data_wr(8'h55);
        data_rd();
        check8("part id after write", PART_CODE, v);
        xfer(2'b11, 8'h01, v);
        xfer(2'b10, 8'h00, v);
        check8("select readback", 8'h01, v);
        data_wr(8'h55);
        data_rd();
        check8("revision", REV_CODE, v);
        xfer(2'b11, 8'hB4, v);
        data_rd();
        check8("locked flash read", 8'h00, v);
        data_wr(8'h07);
        check8("locked pulses", 8'h00, 8'(wr_pulses + rd_pulses));
        xfer(2'b11, 8'h02, v);
        data_wr(8'h01);
        data_wr(8'h02);
        check8("half unlock", 8'h00, {7'h00, flash_prog_enabled});
        data_wr(8'h01);
        data_rd();
        check8("control readback", 8'h01, v);
        check8("unlocked", 8'h01, {7'h00, flash_prog_enabled});
        xfer(2'b11, 8'hB4, v);
        @(negedge clk) flash_cmd_phase = 1'b1;
        foreach (cmds[i]) begin
            data_wr(cmds[i]);
            check8("command", cmds[i], flash_cmd);
            check8("command bad", 8'h00, {7'h00, flash_cmd_bad});
        end
        data_wr(8'h55);
        check8("bad command flag", 8'h01, {7'h00, flash_cmd_bad});
        check8("command kept", 8'h03, flash_cmd);
        @(negedge clk) flash_cmd_phase = 1'b0;
        data_wr(8'h9C);
        check8("flash data", 8'h9C, flash_prog_data);
        data_rd();
        check8("flash read", 8'h3E, v);
        check8("write pulses", 8'h06, 8'(wr_pulses));
        check8("read pulses", 8'h01, 8'(rd_pulses));
        xfer(2'b11, 8'h77, v);
        data_rd();
        check8("unmapped read", 8'h00, v);
        do_reset();
        check8("select after reset", 8'h00, debug_target_select);
        check8("lock after reset", 8'h00, {7'h00, flash_prog_enabled});
        data_rd();
        check8("part id", PART_CODE, v);
        stop_test();
    end
endmodule

bind debug_link debug_link_assertions chk_u (.clk(clk), .rst_b(rst_b),
    .debug_clock_pin(debug_clock_pin), .debug_data_oe_b(debug_data_oe_b),
    .debug_target_select(debug_target_select), .flash_prog_enabled(flash_prog_enabled),
    .flash_data_wr(flash_data_wr), .flash_data_rd(flash_data_rd), .flash_cmd(flash_cmd),
    .flash_prog_control(flash_prog_control));
